// >>> soft_reset_defines.vh
`ifndef SOFT_RESET_DEFINES_VH
`define SOFT_RESET_DEFINES_VH
// register byte addresses
`define ADDR_PERIPH_ONE  12'h044
`define ADDR_PORT        12'h048
// reset value of both registers
`define SOFT_RESET_INIT  32'h00000000
// writable bits of each register
`define PERIPH_ONE_USED  32'h070F5037
`define PORT_USED        32'h000000FF
// field positions in the first register
`define POS_COMPARATOR0_RESET        24
`define POS_GPC0         16
`define POS_TWO_WIRE0    12
`define POS_TWO_WIRE1    14
`define POS_SYNC0        4
`define POS_ASYNC0       0
// field widths in the first register
`define WIDTH_COMP       3
`define WIDTH_GPC        4
`define WIDTH_SYNC       2
`define WIDTH_ASYNC      3
// single unit positions in the first register
`define POS_COMPARATOR1_RESET        25
`define POS_COMPARATOR2_RESET        26
`define POS_GPC1         17
`define POS_GPC2         18
`define POS_GPC3         19
`define POS_SYNC1        5
`define POS_ASYNC1       1
`define POS_ASYNC2       2
// pin port positions in the port register
`define POS_PORT_A       0
`define POS_PORT_B       1
`define POS_PORT_C       2
`define POS_PORT_D       3
`define POS_PORT_E       4
`define POS_PORT_F       5
`define POS_PORT_G       6
`define POS_PORT_H       7
`define WIDTH_PORT       8
// data bits covered by one byte strobe
`define BYTE_BITS        8
// read value of an unmapped address
`define READ_IDLE        32'h00000000
`endif

// >>> software_peripheral_reset_control.v
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`include "soft_reset_defines.vh"
module software_peripheral_reset_control
#(
  // bus widths
  parameter ADDR_WIDTH = 12,
  parameter DATA_WIDTH = 32,
  parameter STRB_WIDTH = 4
)
(
  // clock and reset
  input  wire                     clock,
  input  wire                     rst_n,
  // apb slave
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [ADDR_WIDTH-1:0]    paddr,
  input  wire [DATA_WIDTH-1:0]    pwdata,
  input  wire [STRB_WIDTH-1:0]    pstrb,
  output wire                     pready,
  output wire                     pslverr,
  output reg  [DATA_WIDTH-1:0]    prdata,
  // device capability masks, one bit per present unit
  input  wire [DATA_WIDTH-1:0]    capability_mask_two,
  input  wire [DATA_WIDTH-1:0]    capability_mask_four,
  // peripheral reset outputs, high holds the unit in reset
  output wire [`WIDTH_COMP-1:0]   comparator_reset,
  output wire [`WIDTH_GPC-1:0]    gp_counter_reset,
  output wire                     two_wire_unit1_reset,
  output wire                     two_wire_unit0_reset,
  output wire [`WIDTH_SYNC-1:0]   sync_serial_reset,
  output wire [`WIDTH_ASYNC-1:0]  async_serial_reset,
  output wire [`WIDTH_PORT-1:0]   pin_port_reset
);

  // data bits covered by one byte strobe
  localparam LANE_BITS = `BYTE_BITS;

  // read source codes
  localparam [1:0] SEL_NONE = 2'h0;
  localparam [1:0] SEL_ONE  = 2'h1;
  localparam [1:0] SEL_PORT = 2'h2;

  // reset release pair
  reg                   rst_meta;
  reg                   rst_sync_n;

  // stored control registers
  reg  [DATA_WIDTH-1:0] peripheral_soft_reset_one;
  reg  [DATA_WIDTH-1:0] port_soft_reset;

  // values a write would leave behind
  wire [DATA_WIDTH-1:0] next_peripheral_soft_reset_one;
  wire [DATA_WIDTH-1:0] next_port_soft_reset;

  // byte strobes spread to bits
  wire [DATA_WIDTH-1:0] lane_mask;

  // bits of present units, and bits a write may change
  wire [DATA_WIDTH-1:0] present_one;
  wire [DATA_WIDTH-1:0] present_port;
  wire [DATA_WIDTH-1:0] write_mask_one;
  wire [DATA_WIDTH-1:0] write_mask_port;

  // read path
  reg  [DATA_WIDTH-1:0] next_prdata;
  wire [1:0]            read_select;

  // bus decode
  wire                  access;
  wire                  setup_read;
  wire                  wr;
  wire                  hit_one;
  wire                  hit_port;
  wire                  hit_any;
  wire                  miss;
  wire                  wr_one;
  wire                  wr_port;

  // one line per unit, named for the unit it holds in reset
  wire                  comparator2_reset;
  wire                  comparator1_reset;
  wire                  comparator0_reset;
  wire                  gp_counter3_reset;
  wire                  gp_counter2_reset;
  wire                  gp_counter1_reset;
  wire                  gp_counter0_reset;
  wire                  sync_serial_unit1_reset;
  wire                  sync_serial_unit0_reset;
  wire                  async_serial_port2_reset;
  wire                  async_serial_port1_reset;
  wire                  async_serial_port0_reset;
  wire                  pin_port_h_reset;
  wire                  pin_port_g_reset;
  wire                  pin_port_f_reset;
  wire                  pin_port_e_reset;
  wire                  pin_port_d_reset;
  wire                  pin_port_c_reset;
  wire                  pin_port_b_reset;
  wire                  pin_port_a_reset;

  // reset release through two flops, assertion stays asynchronous
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // setup-read and access phase strobes; a write lands at the edge that ends the access phase
  assign access     = psel & penable;
  assign setup_read = psel & ~penable & ~pwrite;
  assign wr         = access & pwrite;

  // address decode against the two word offsets
  assign hit_one  = (paddr == `ADDR_PERIPH_ONE);
  assign hit_port = (paddr == `ADDR_PORT);
  assign hit_any  = hit_one | hit_port;
  assign miss     = ~hit_any;
  assign wr_one   = wr & hit_one;
  assign wr_port  = wr & hit_port;

  // zero-wait slave; an unmapped access errors rather than hangs
  assign pready  = 1'b1;
  assign pslverr = access & miss;

  // units that exist on this die; absent ones ignore writes
  assign present_one  = capability_mask_two & `PERIPH_ONE_USED;
  assign present_port = capability_mask_four & `PORT_USED;

  // strobe and presence must both allow a bit to change
  assign write_mask_one  = lane_mask & present_one;
  assign write_mask_port = lane_mask & present_port;

  // one slice per data bit: strobe lane and merged next value
  genvar bit_index;
  generate
    for (bit_index = 0; bit_index < DATA_WIDTH; bit_index = bit_index + 1)
    begin : bit_slice
      assign lane_mask[bit_index] = pstrb[bit_index / LANE_BITS];
      assign next_peripheral_soft_reset_one[bit_index] =
        write_mask_one[bit_index] ?
        pwdata[bit_index] :
        peripheral_soft_reset_one[bit_index];
      assign next_port_soft_reset[bit_index] =
        write_mask_port[bit_index] ?
        pwdata[bit_index] :
        port_soft_reset[bit_index];
    end
  endgenerate

  // first register; unused bits never leave zero
  always @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      peripheral_soft_reset_one <= `SOFT_RESET_INIT;
    end
    else if (wr_one)
    begin
      peripheral_soft_reset_one <= next_peripheral_soft_reset_one;
    end
  end

  // port register; cleared with the system reset like the first
  always @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      port_soft_reset <= `SOFT_RESET_INIT;
    end
    else if (wr_port)
    begin
      port_soft_reset <= next_port_soft_reset;
    end
  end

  // read source picked from the decode
  assign read_select = {hit_port, hit_one};

  // read mux; reads ignore capability masks and show stored bits
  always @*
  begin
    next_prdata = `READ_IDLE;
    case (read_select)
      SEL_ONE:
      begin
        next_prdata = peripheral_soft_reset_one & `PERIPH_ONE_USED;
      end
      SEL_PORT:
      begin
        next_prdata = port_soft_reset & `PORT_USED;
      end
      SEL_NONE:
      begin
        next_prdata = `READ_IDLE;
      end
      default:
      begin
        next_prdata = `READ_IDLE;
      end
    endcase
  end

  // read data taken in setup so it stands through the access phase
  always @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      prdata <= `READ_IDLE;
    end
    else if (setup_read)
    begin
      prdata <= next_prdata;
    end
  end

  // comparator 2
  assign comparator2_reset = peripheral_soft_reset_one[`POS_COMPARATOR2_RESET];

  // comparator 1
  assign comparator1_reset = peripheral_soft_reset_one[`POS_COMPARATOR1_RESET];

  // comparator 0
  assign comparator0_reset = peripheral_soft_reset_one[`POS_COMPARATOR0_RESET];

  // counter 3
  assign gp_counter3_reset = peripheral_soft_reset_one[`POS_GPC3];

  // counter 2
  assign gp_counter2_reset = peripheral_soft_reset_one[`POS_GPC2];

  // counter 1
  assign gp_counter1_reset = peripheral_soft_reset_one[`POS_GPC1];

  // counter 0
  assign gp_counter0_reset = peripheral_soft_reset_one[`POS_GPC0];

  // two-wire unit 1
  assign two_wire_unit1_reset = peripheral_soft_reset_one[`POS_TWO_WIRE1];

  // two-wire unit 0
  assign two_wire_unit0_reset = peripheral_soft_reset_one[`POS_TWO_WIRE0];

  // sync serial unit 1
  assign sync_serial_unit1_reset = peripheral_soft_reset_one[`POS_SYNC1];

  // sync serial unit 0
  assign sync_serial_unit0_reset = peripheral_soft_reset_one[`POS_SYNC0];

  // async serial port 2
  assign async_serial_port2_reset = peripheral_soft_reset_one[`POS_ASYNC2];

  // async serial port 1
  assign async_serial_port1_reset = peripheral_soft_reset_one[`POS_ASYNC1];

  // async serial port 0
  assign async_serial_port0_reset = peripheral_soft_reset_one[`POS_ASYNC0];

  // pin port h
  assign pin_port_h_reset = port_soft_reset[`POS_PORT_H];

  // pin port g
  assign pin_port_g_reset = port_soft_reset[`POS_PORT_G];

  // pin port f
  assign pin_port_f_reset = port_soft_reset[`POS_PORT_F];

  // pin port e
  assign pin_port_e_reset = port_soft_reset[`POS_PORT_E];

  // pin port d
  assign pin_port_d_reset = port_soft_reset[`POS_PORT_D];

  // pin port c
  assign pin_port_c_reset = port_soft_reset[`POS_PORT_C];

  // pin port b
  assign pin_port_b_reset = port_soft_reset[`POS_PORT_B];

  // pin port a
  assign pin_port_a_reset = port_soft_reset[`POS_PORT_A];

  // grouped outputs; no stretching, a cleared bit releases at once
  assign comparator_reset   = {comparator2_reset, comparator1_reset,
                               comparator0_reset};
  assign gp_counter_reset   = {gp_counter3_reset, gp_counter2_reset,
                               gp_counter1_reset, gp_counter0_reset};
  assign sync_serial_reset  = {sync_serial_unit1_reset,
                               sync_serial_unit0_reset};
  assign async_serial_reset = {async_serial_port2_reset, async_serial_port1_reset,
                               async_serial_port0_reset};
  assign pin_port_reset     = {pin_port_h_reset, pin_port_g_reset,
                               pin_port_f_reset, pin_port_e_reset,
                               pin_port_d_reset, pin_port_c_reset,
                               pin_port_b_reset, pin_port_a_reset};

endmodule // software_peripheral_reset_control

// >>> srst_properties.sv
`timescale 1ns/1ns
module srst_properties
(
  // bus side
  input wire        clock, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata, capability_mask_two, capability_mask_four,
  input wire [3:0]  pstrb,
  // reset outputs
  input wire [2:0]  comparator_reset, async_serial_reset,
  input wire [3:0]  gp_counter_reset,
  input wire        two_wire_unit1_reset, two_wire_unit0_reset,
  input wire [1:0]  sync_serial_reset,
  input wire [7:0]  pin_port_reset
);
  // first register rebuilt from its fields; absent units keep old bits
  wire [31:0] r1 = {5'h00, comparator_reset, 4'h0, gp_counter_reset, 1'b0, two_wire_unit1_reset,
    1'b0, two_wire_unit0_reset, 6'h00, sync_serial_reset, 1'b0, async_serial_reset};
  wire acc = psel & penable;
  wire wf = acc & pwrite & (pstrb == 4'hF);
  wire [31:0] m2 = capability_mask_two;
  wire [7:0] m4 = capability_mask_four[7:0];
  // expected register contents after a full-word write
  wire [31:0] exp1 = (r1 & ~m2) | (pwdata & m2 & 32'h070F5037);
  wire [7:0] exp4 = (pin_port_reset & ~m4) | (pwdata[7:0] & m4);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_first_write: assert property
    (wf && paddr == 12'h044 |=> r1 == $past(exp1)) else $error("w1");
  a_port_write: assert property
    (wf && paddr == 12'h048 |=> pin_port_reset == $past(exp4)) else $error("w2");
  a_outputs_hold: assert property (!(acc && pwrite) |=> $stable(r1) && $stable(pin_port_reset)) else $error("hold");
  a_reset_clear: assert property (disable iff (1'b0) !rst_n && !$past(rst_n) |-> r1 == 32'h0 && pin_port_reset == 8'h00) else $error("rst");
  a_read_first: assert property (acc && !pwrite && paddr == 12'h044 |-> prdata == r1) else $error("r1");
  a_read_port: assert property (acc && !pwrite && paddr == 12'h048 |-> prdata == {24'h0, pin_port_reset}) else $error("r2");
  a_unmapped_err: assert property (acc && paddr != 12'h044 && paddr != 12'h048 |-> pslverr) else $error("err");
  a_zero_wait: assert property (acc |-> pready) else $error("rdy");
endmodule // srst_properties
bind software_peripheral_reset_control srst_properties srst_properties_inst (.*);

// >>> software_peripheral_reset_control_tb.sv
`timescale 1ns/1ns
module software_peripheral_reset_control_tb;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 0, prdata, capability_mask_two = 0, capability_mask_four = 0, rd;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] comparator_reset, async_serial_reset;
  logic [3:0] gp_counter_reset;
  logic two_wire_unit1_reset, two_wire_unit0_reset;
  logic [1:0] sync_serial_reset;
  logic [7:0] pin_port_reset;
  int miscompares = 0, tests_run = 0, cyc = 0;
  software_peripheral_reset_control software_peripheral_reset_control_inst (.*);
  always #2 clock = ~clock;
  // one apb transfer, request held until pready is seen
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock) penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    @(posedge clock);
  endtask
  task chk(input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin miscompares++; $display("mismatch %0t %h %h", $time, s, e); end
  endtask
  task report_and_stop;
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clock) if (++cyc > 500) begin miscompares++; report_and_stop; end
  initial begin
    repeat (6) @(posedge clock); rst_n <= 1; repeat (3) @(posedge clock);
    xf(0, 12'h044, 0); chk(rd, 0);
    xf(0, 12'h048, 0); chk(rd, 0);
    capability_mask_two <= '1; capability_mask_four <= 32'h0000000F;
    xf(1, 12'h044, '1); xf(0, 12'h044, 0); chk(rd, 32'h070F5037);
    chk({comparator_reset, gp_counter_reset, two_wire_unit1_reset, two_wire_unit0_reset,
      sync_serial_reset, async_serial_reset}, 32'h3FFF);
    capability_mask_two <= 32'h01000001;
    xf(1, 12'h044, 0); xf(0, 12'h044, 0); chk(rd, 32'h060F5036);
    chk(comparator_reset, 3'h6);
    xf(1, 12'h048, '1); xf(0, 12'h048, 0); chk(rd, 32'h0000000F);
    chk(pin_port_reset, 8'h0F);
    xf(0, 12'h04C, 0); chk(er, 1'b1); chk(rd, 0);
    capability_mask_four <= 32'h000000FF; // read-modify-write writes back read bits
    xf(0, 12'h048, 0); xf(1, 12'h048, rd | 32'h00000010); xf(0, 12'h048, 0);
    chk(rd, 32'h0000001F);
    rst_n <= 0; repeat (2) @(posedge clock); rst_n <= 1; repeat (3) @(posedge clock);
    chk(pin_port_reset, 8'h00);
    xf(0, 12'h044, 0); chk(rd, 0);
    capability_mask_two <= '1; pstrb <= 4'h1;
    xf(1, 12'h044, '1); pstrb <= 4'hF; xf(0, 12'h044, 0);
    chk(rd, 32'h00000037);
    report_and_stop;
  end
endmodule // software_peripheral_reset_control_tb
